// File: dss_pkg.sv
// Constants, types and register layout of the dual-sink selector
package dss_pkg;

    // =====================================================================
    // Timing
    localparam int HPD_TIMEOUT_MS  = 350;
    localparam int CLK_FREQ_HZ     = 25_000_000;
    localparam int HPD_TIMEOUT_CYC = HPD_TIMEOUT_MS * (CLK_FREQ_HZ / 1000);

    // =====================================================================
    // Register map (byte addresses)
    localparam logic [3:0] ADDR_CTRL       = 4'h0;
    localparam logic [3:0] ADDR_LEVEL_GAIN = 4'h4;
    localparam logic [3:0] ADDR_LANE_GAIN  = 4'h8;
    localparam logic [3:0] ADDR_STATUS     = 4'hC;

    // Control register fields
    localparam int CTRL_FORCE_POS    = 0;
    localparam int CTRL_FORCE_HPD    = 1;
    localparam int CTRL_FORCE_CAD    = 2;
    localparam int CTRL_EQ_REG_POS   = 3;
    localparam int CTRL_TRAIN_EN_POS = 4;
    localparam int CTRL_WIDTH        = 5;
    localparam logic [4:0]  CTRL_RESET       = 5'h10;
    localparam logic [15:0] LEVEL_GAIN_RESET = 16'h0000;
    localparam logic [15:0] LANE_GAIN_RESET  = 16'h0000;

    // =====================================================================
    // Equalizer gain codes
    localparam logic [3:0] GAIN_0DB   = 4'h0;
    localparam logic [3:0] GAIN_3DB   = 4'h1;
    localparam logic [3:0] GAIN_3P5DB = 4'h2;
    localparam logic [3:0] GAIN_6DB   = 4'h3;
    localparam logic [3:0] GAIN_8DB   = 4'h4;
    localparam logic [3:0] GAIN_10DB  = 4'h5;
    localparam logic [3:0] GAIN_13DB  = 4'h6;
    localparam logic [3:0] GAIN_15DB  = 4'h7;
    localparam logic [3:0] GAIN_18DB  = 4'h8;

    // Three-level pin codes (thermometer: bit0 at or above middle, bit1 high)
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_MID = 2'h1;

    // =====================================================================
    // Types
    typedef enum logic [1:0] {
        DSS_ST_IDLE,
        DSS_ST_PACKET,
        DSS_ST_TMDS,
        DSS_ST_SWITCH
    } dss_state_t;

    typedef struct packed {
        logic source_aux_sw;
        logic source_ddc_sw;
        logic sink_aux_sw;
        logic level_shift_buf;
        logic aux_monitor;
        logic id_buffer;
    } dss_switch_t;

    localparam dss_switch_t SWITCH_OFF = '0;

endpackage : dss_pkg

// File: dss_select.sv
// Sink selection, hot-plug timing, AUX/DDC switch and equalizer control
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module dss_select #(
    parameter int HPD_TIMEOUT = dss_pkg::HPD_TIMEOUT_CYC,
    parameter int LANES       = 4
) (
    input  wire logic                 i_core_clk,
    input  wire logic                 i_arst_n,
    input  wire logic                 i_enable,
    input  wire logic                 i_packet_sink_hotplug_in,
    input  wire logic                 i_tmds_sink_hotplug_in,
    input  wire logic                 i_sink_adapter_detect_in,
    input  wire logic                 i_priority,
    input  wire logic [1:0]           i_three_level_control_enable,
    input  wire logic [1:0]           i_equalizer_level_pin,
    input  wire logic                 i_link_training_done,
    input  wire logic [LANES-1:0][1:0] i_lane_training_level,
    input  wire logic [1:0]           i_sink_ddc_low,
    input  wire logic [1:0]           i_source_ddc_below_vil,
    input  wire logic [3:0]           i_reg_addr,
    input  wire logic [31:0]          i_reg_wdata,
    input  wire logic                 i_reg_wr,
    input  wire logic                 i_reg_rd,
    output logic [31:0]               o_reg_rdata,
    output logic                      o_source_hotplug_out,
    output logic                      o_source_adapter_detect_out,
    output logic                      o_source_ddc_pullup_en,
    output dss_pkg::dss_switch_t      o_switches,
    output logic [1:0]                o_source_ddc_oe_n,
    output logic [1:0]                o_sink_ddc_oe_n,
    output logic                      o_packet_mode,
    output logic                      o_tmds_mode,
    output logic [LANES-1:0]          o_lane_en,
    output logic [LANES-1:0][3:0]     o_lane_eq_gain
);

    localparam int TW = $clog2(HPD_TIMEOUT + 1);
    localparam logic [TW-1:0] TIMEOUT_LAST = TW'(HPD_TIMEOUT - 1);

    // =====================================================================
    // Pin synchronisers: three stages, change accepted when stages 2 and 3 agree
    localparam int NS = 13;
    logic [NS-1:0] pin_raw;
    logic [NS-1:0] sync1_reg;
    logic [NS-1:0] sync2_reg;
    logic [NS-1:0] sync3_reg;
    logic [NS-1:0] pin_reg;
    logic [NS-1:0] pin_next;

    assign pin_raw = {i_source_ddc_below_vil, i_sink_ddc_low, i_equalizer_level_pin,
                      i_three_level_control_enable, i_priority, i_sink_adapter_detect_in,
                      i_tmds_sink_hotplug_in, i_packet_sink_hotplug_in, i_enable};
    assign pin_next = (sync2_reg & sync3_reg) | (pin_reg & (sync2_reg | sync3_reg));

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            pin_reg   <= '0;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            pin_reg   <= pin_next;
        end
    end

    logic       en;
    logic [1:0] hpd_in;
    logic       cad_in;
    logic       prio;
    logic [1:0] cte_lvl;
    logic [1:0] eq_pin_lvl;
    logic [1:0] snk_low;
    logic [1:0] src_low;

    assign en         = pin_reg[0];
    assign hpd_in     = pin_reg[2:1];
    assign cad_in     = pin_reg[3];
    assign prio       = pin_reg[4];
    assign cte_lvl    = pin_reg[6:5];
    assign eq_pin_lvl = pin_reg[8:7];
    assign snk_low    = pin_reg[10:9];
    assign src_low    = pin_reg[12:11];

    // =====================================================================
    // Register file
    logic [dss_pkg::CTRL_WIDTH-1:0] ctrl_reg;
    logic [15:0]                    level_gain_reg;
    logic [15:0]                    lane_gain_reg;
    logic [31:0]                    rdata_reg;
    logic [31:0]                    rdata_next;
    logic [31:0]                    status_word;
    logic                           wr_ctrl;
    logic                           wr_level;
    logic                           wr_lane;

    assign wr_ctrl  = i_reg_wr && (i_reg_addr == dss_pkg::ADDR_CTRL);
    assign wr_level = i_reg_wr && (i_reg_addr == dss_pkg::ADDR_LEVEL_GAIN);
    assign wr_lane  = i_reg_wr && (i_reg_addr == dss_pkg::ADDR_LANE_GAIN);

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_reg       <= dss_pkg::CTRL_RESET;
            level_gain_reg <= dss_pkg::LEVEL_GAIN_RESET;
            lane_gain_reg  <= dss_pkg::LANE_GAIN_RESET;
        end else if (!en) begin
            ctrl_reg       <= dss_pkg::CTRL_RESET;
            level_gain_reg <= dss_pkg::LEVEL_GAIN_RESET;
            lane_gain_reg  <= dss_pkg::LANE_GAIN_RESET;
        end else begin
            if (wr_ctrl)
                ctrl_reg <= i_reg_wdata[dss_pkg::CTRL_WIDTH-1:0];
            if (wr_level)
                level_gain_reg <= i_reg_wdata[15:0];
            if (wr_lane)
                lane_gain_reg <= i_reg_wdata[15:0];
        end
    end

    logic force_mode;
    logic eq_reg_ctrl;
    logic train_en;

    assign force_mode  = ctrl_reg[dss_pkg::CTRL_FORCE_POS];
    assign eq_reg_ctrl = ctrl_reg[dss_pkg::CTRL_EQ_REG_POS];
    assign train_en    = ctrl_reg[dss_pkg::CTRL_TRAIN_EN_POS];

    // =====================================================================
    // Sink presence: removal after the full low timeout, or at once while disabled
    logic [1:0] conn;

    genvar s;
    generate
        for (s = 0; s < 2; s++) begin : g_sink
            logic [TW-1:0] low_cnt_reg;
            logic          conn_reg;

            always_ff @(posedge i_core_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    low_cnt_reg <= '0;
                    conn_reg    <= 1'b0;
                end else if (!en) begin
                    low_cnt_reg <= '0;
                    conn_reg    <= 1'b0;
                end else if (hpd_in[s]) begin
                    low_cnt_reg <= '0;
                    conn_reg    <= 1'b1;
                end else if (conn_reg) begin
                    low_cnt_reg <= low_cnt_reg + TW'(1);
                    if (low_cnt_reg == TIMEOUT_LAST)
                        conn_reg <= 1'b0;
                end
            end

            assign conn[s] = conn_reg;
        end
    endgenerate

    // =====================================================================
    // Selection state machine
    logic want_pkt;
    logic want_tmds;

    assign want_pkt  = conn[0] && (!conn[1] || !prio);
    assign want_tmds = conn[1] && (!conn[0] || prio);

    dss_pkg::dss_state_t state_reg;
    dss_pkg::dss_state_t state_next;
    logic [TW-1:0]       sw_cnt_reg;
    logic                target_tmds_reg;
    logic                last_tmds_reg;
    logic                sw_done;

    assign sw_done = (sw_cnt_reg == TIMEOUT_LAST);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dss_pkg::DSS_ST_IDLE: begin
                if (want_pkt)
                    state_next = dss_pkg::DSS_ST_PACKET;
                else if (want_tmds)
                    state_next = dss_pkg::DSS_ST_TMDS;
            end
            dss_pkg::DSS_ST_PACKET: begin
                if (!conn[0])
                    state_next = dss_pkg::DSS_ST_IDLE;
                else if (want_tmds)
                    state_next = dss_pkg::DSS_ST_SWITCH;
            end
            dss_pkg::DSS_ST_TMDS: begin
                if (!conn[1])
                    state_next = dss_pkg::DSS_ST_IDLE;
                else if (want_pkt)
                    state_next = dss_pkg::DSS_ST_SWITCH;
            end
            dss_pkg::DSS_ST_SWITCH: begin
                if (sw_done) begin
                    if (target_tmds_reg && want_tmds)
                        state_next = dss_pkg::DSS_ST_TMDS;
                    else if (!target_tmds_reg && want_pkt)
                        state_next = dss_pkg::DSS_ST_PACKET;
                    else
                        state_next = dss_pkg::DSS_ST_IDLE;
                end
            end
            default: state_next = dss_pkg::DSS_ST_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg       <= dss_pkg::DSS_ST_IDLE;
            sw_cnt_reg      <= '0;
            target_tmds_reg <= 1'b0;
            last_tmds_reg   <= 1'b0;
        end else if (!en) begin
            state_reg       <= dss_pkg::DSS_ST_IDLE;
            sw_cnt_reg      <= '0;
            target_tmds_reg <= 1'b0;
            last_tmds_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == dss_pkg::DSS_ST_SWITCH)
                sw_cnt_reg <= sw_cnt_reg + TW'(1);
            else
                sw_cnt_reg <= '0;
            if (state_next == dss_pkg::DSS_ST_SWITCH && state_reg != dss_pkg::DSS_ST_SWITCH)
                target_tmds_reg <= (state_reg == dss_pkg::DSS_ST_PACKET);
            if (state_reg == dss_pkg::DSS_ST_TMDS)
                last_tmds_reg <= 1'b1;
            else if (state_reg == dss_pkg::DSS_ST_PACKET)
                last_tmds_reg <= 1'b0;
        end
    end

    // =====================================================================
    // Hot-plug, adapter-detect and switch decode
    logic                 sel_pkt;
    logic                 sel_tmds;
    logic                 pkt_mode;
    logic                 tmds_mode;
    logic                 hpd_next;
    logic                 cad_next;
    logic                 cad_auto;
    dss_pkg::dss_switch_t sw_next;

    assign sel_pkt   = en && (state_reg == dss_pkg::DSS_ST_PACKET);
    assign sel_tmds  = en && (state_reg == dss_pkg::DSS_ST_TMDS);
    assign pkt_mode  = sel_pkt && !cad_in;
    assign tmds_mode = (sel_pkt && cad_in) || sel_tmds;

    assign cad_auto = sel_pkt  ? cad_in :
                      sel_tmds ? 1'b1 :
                      (en && state_reg == dss_pkg::DSS_ST_IDLE) ? (last_tmds_reg | cad_in) :
                      1'b0;

    assign hpd_next = !en        ? (hpd_in[0] | hpd_in[1]) :
                      force_mode ? ctrl_reg[dss_pkg::CTRL_FORCE_HPD] :
                      (sel_pkt || sel_tmds);

    assign cad_next = (en && force_mode) ? ctrl_reg[dss_pkg::CTRL_FORCE_CAD] : cad_auto;

    always_comb begin
        sw_next = dss_pkg::SWITCH_OFF;
        if (pkt_mode) begin
            sw_next.source_aux_sw = 1'b1;
            sw_next.sink_aux_sw   = 1'b1;
            sw_next.aux_monitor   = 1'b1;
        end else if (sel_pkt) begin
            sw_next.source_ddc_sw = 1'b1;
            sw_next.sink_aux_sw   = 1'b1;
        end else if (sel_tmds) begin
            sw_next.source_ddc_sw   = 1'b1;
            sw_next.level_shift_buf = 1'b1;
            sw_next.id_buffer       = 1'b1;
        end
    end

    // =====================================================================
    // Display-data buffer drivers (both lines)
    logic [1:0] src_drive;
    logic [1:0] snk_drive;

    assign src_drive = {2{sw_next.level_shift_buf}} & snk_low;
    assign snk_drive = {2{sw_next.level_shift_buf}} & src_low;

    // =====================================================================
    // Equalizer gain selection per lane
    logic [3:0] pin_level_gain [4];
    logic [3:0] mid_level_gain [4];
    logic [3:0] pin_fixed_gain;
    logic       use_training;

    assign pin_level_gain[0] = dss_pkg::GAIN_8DB;
    assign pin_level_gain[1] = dss_pkg::GAIN_6DB;
    assign pin_level_gain[2] = dss_pkg::GAIN_3P5DB;
    assign pin_level_gain[3] = dss_pkg::GAIN_0DB;
    assign mid_level_gain[0] = dss_pkg::GAIN_15DB;
    assign mid_level_gain[1] = dss_pkg::GAIN_13DB;
    assign mid_level_gain[2] = dss_pkg::GAIN_10DB;
    assign mid_level_gain[3] = dss_pkg::GAIN_6DB;

    assign use_training = pkt_mode && train_en && i_link_training_done;

    assign pin_fixed_gain = (cte_lvl == dss_pkg::LVL_LOW) ?
                                ((eq_pin_lvl == dss_pkg::LVL_LOW) ? dss_pkg::GAIN_6DB :
                                 (eq_pin_lvl == dss_pkg::LVL_MID) ? dss_pkg::GAIN_6DB :
                                                                    dss_pkg::GAIN_13DB) :
                            (cte_lvl == dss_pkg::LVL_MID) ? dss_pkg::GAIN_13DB :
                                                            dss_pkg::GAIN_18DB;

    logic [LANES-1:0][3:0] gain_next;
    logic [LANES-1:0]      lane_en_next;

    genvar l;
    generate
        for (l = 0; l < LANES; l++) begin : g_lane
            logic [1:0] lvl;
            logic [3:0] pin_gain;
            logic [3:0] reg_gain;

            assign lvl = i_lane_training_level[l];
            assign pin_gain = (use_training && cte_lvl == dss_pkg::LVL_LOW &&
                               eq_pin_lvl == dss_pkg::LVL_LOW) ? pin_level_gain[lvl] :
                              (use_training && cte_lvl == dss_pkg::LVL_MID) ?
                               mid_level_gain[lvl] : pin_fixed_gain;
            assign reg_gain = use_training ? level_gain_reg[4*lvl +: 4] :
                                             lane_gain_reg[(4*(l % 4)) +: 4];
            assign gain_next[l] = (tmds_mode && l == LANES - 1) ? dss_pkg::GAIN_3DB :
                                  eq_reg_ctrl ? reg_gain : pin_gain;
            assign lane_en_next[l] = en && (sel_pkt || sel_tmds);
        end
    endgenerate

    // =====================================================================
    // Registered outputs and read port
    assign status_word = {23'h000000, cad_in, hpd_in, conn, state_reg, o_source_adapter_detect_out,
                          o_source_hotplug_out};

    always_comb begin
        case (i_reg_addr)
            dss_pkg::ADDR_CTRL:       rdata_next = {27'h0000000, ctrl_reg};
            dss_pkg::ADDR_LEVEL_GAIN: rdata_next = {16'h0000, level_gain_reg};
            dss_pkg::ADDR_LANE_GAIN:  rdata_next = {16'h0000, lane_gain_reg};
            dss_pkg::ADDR_STATUS:     rdata_next = status_word;
            default:                  rdata_next = 32'h00000000;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_reg                   <= 32'h00000000;
            o_source_hotplug_out        <= 1'b0;
            o_source_adapter_detect_out <= 1'b0;
            o_switches                  <= dss_pkg::SWITCH_OFF;
            o_source_ddc_oe_n           <= 2'h3;
            o_sink_ddc_oe_n             <= 2'h3;
            o_packet_mode               <= 1'b0;
            o_tmds_mode                 <= 1'b0;
            o_lane_en                   <= '0;
            o_lane_eq_gain              <= '0;
        end else begin
            rdata_reg                   <= i_reg_rd ? rdata_next : 32'h00000000;
            o_source_hotplug_out        <= hpd_next;
            o_source_adapter_detect_out <= cad_next;
            o_switches                  <= sw_next;
            o_source_ddc_oe_n           <= ~src_drive;
            o_sink_ddc_oe_n             <= ~snk_drive;
            o_packet_mode               <= pkt_mode;
            o_tmds_mode                 <= tmds_mode;
            o_lane_en                   <= lane_en_next;
            o_lane_eq_gain              <= gain_next;
        end
    end

    assign o_reg_rdata            = rdata_reg;
    assign o_source_ddc_pullup_en = o_source_adapter_detect_out;

endmodule : dss_select

// File: dss_select_chk.sv
// Port checker of the dual-sink selector
`timescale 1ns/10ps
module dss_select_chk #(parameter int LANES = 4) (
    input logic i_core_clk,
    input logic i_arst_n,
    input logic i_enable,
    input logic i_packet_sink_hotplug_in,
    input logic o_source_hotplug_out,
    input logic o_source_adapter_detect_out,
    input logic o_source_ddc_pullup_en,
    input dss_pkg::dss_switch_t o_switches,
    input logic o_packet_mode,
    input logic o_tmds_mode,
    input logic [LANES-1:0] o_lane_en,
    input logic [LANES-1:0][3:0] o_lane_eq_gain
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    chk_pullup_follow:
        assert property (o_source_ddc_pullup_en == o_source_adapter_detect_out) else $error("pull-up mismatch");
    chk_packet_cad_low:
        assert property (o_packet_mode |-> !o_source_adapter_detect_out && !o_tmds_mode) else $error("packet cad");
    chk_monitor_aux:
        assert property (o_switches.aux_monitor |-> o_switches.source_aux_sw && o_switches.sink_aux_sw
            && !o_switches.source_ddc_sw) else $error("monitor without aux");
    chk_ddc_aux_cad:
        assert property (o_switches.source_ddc_sw && o_switches.sink_aux_sw |-> o_source_adapter_detect_out
            && !o_switches.aux_monitor) else $error("ddc to aux setup");
    chk_tmds_buffers:
        assert property (o_switches.id_buffer |-> o_switches.level_shift_buf && !o_switches.sink_aux_sw
            && o_source_adapter_detect_out) else $error("tmds setup");
    chk_clock_lane:
        assert property (o_tmds_mode |-> o_lane_eq_gain[LANES-1] == dss_pkg::GAIN_3DB) else $error("clock lane");
    chk_lanes_off:
        assert property (!i_enable [*5] |=> o_lane_en == '0) else $error("lanes on in shutdown");
    chk_hpd_hold:
        assert property ($fell(i_packet_sink_hotplug_in) && o_packet_mode && i_enable
            |=> o_source_hotplug_out [*8]) else $error("hot-plug dropped early");
    cover property (o_packet_mode);
    cover property (o_switches.id_buffer);
    cover property (!i_enable && o_source_hotplug_out);
endmodule : dss_select_chk
bind dss_select dss_select_chk #(.LANES(LANES)) u_chk (.*);

// File: dss_select_tb.sv
// Testbench of the dual-sink selector
`timescale 1ns/10ps
module dss_select_tb;
    logic clk = 1'b0, arst_n = 1'b0, en = 1'b0, dp = 1'b0, tm = 1'b0, ad = 1'b0;
    logic pri = 1'b0, sl = 1'b0, wr = 1'b0, rd = 1'b0, dp_h, tm_h, cad_i, vil, hpd, cad;
    logic [3:0] addr = 4'h0, lane_en;
    logic [31:0] wd = 32'h0, rdata;
    logic [1:0] oe_src, oe_snk, cte = 2'h0, eqp = 2'h0;
    logic done = 1'b0;
    logic [7:0] lvl = 8'h00;
    logic [15:0] gain;
    dss_pkg::dss_switch_t sw;
    int failures = 0, total_checks = 0;
    always #20 clk = ~clk;
    dss_sink_model u_dss_sink_model (.i_dp_on(dp), .i_tmds_on(tm), .i_adapter(ad), .i_bus_low(sl),
        .o_dp_hpd(dp_h), .o_tmds_hpd(tm_h), .o_cad(cad_i), .o_below_vil(vil));
    dss_select #(.HPD_TIMEOUT(20)) u_dss_select (.i_core_clk(clk), .i_arst_n(arst_n), .i_enable(en),
        .i_packet_sink_hotplug_in(dp_h), .i_tmds_sink_hotplug_in(tm_h), .i_sink_adapter_detect_in(cad_i),
        .i_priority(pri), .i_three_level_control_enable(cte), .i_equalizer_level_pin(eqp),
        .i_link_training_done(done), .i_lane_training_level(lvl), .i_sink_ddc_low(~oe_snk),
        .i_source_ddc_below_vil({1'b0, vil}), .i_reg_addr(addr), .i_reg_wdata(wd), .i_reg_wr(wr),
        .i_reg_rd(rd), .o_reg_rdata(rdata), .o_source_hotplug_out(hpd), .o_source_adapter_detect_out(cad),
        .o_source_ddc_pullup_en(), .o_switches(sw), .o_source_ddc_oe_n(oe_src), .o_sink_ddc_oe_n(oe_snk),
        .o_packet_mode(), .o_tmds_mode(), .o_lane_en(lane_en), .o_lane_eq_gain(gain));
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask : w
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rwr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : rwr
    task automatic rrd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        chk("rdata", e, rdata);
    endtask : rrd
    task automatic t_regs;
        rrd(dss_pkg::ADDR_CTRL, {27'h0, dss_pkg::CTRL_RESET});
        rwr(dss_pkg::ADDR_LANE_GAIN, 32'hFFFF1234);
        rrd(dss_pkg::ADDR_LANE_GAIN, 32'h00001234);
        rrd(4'h2, 32'h0);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_packet;
        dp <= 1'b1;
        w(10);
        chk("hpd", 1, hpd);
        chk("sw", 32'h2A, sw);
        ad <= 1'b1;
        w(10);
        chk("cad", 1, cad);
        chk("sw", 32'h18, sw);
        ad <= 1'b0;
        w(6);
        chk("cad", 0, cad);
        chk("gain", 16'h3333, gain);
        dp <= 1'b0;
        w(5);
        dp <= 1'b1;
        w(3);
        chk("hpd", 1, hpd);
        $display("t_packet done");
    endtask : t_packet
    task automatic t_eq;
        cte <= 2'h1;
        w(6);
        chk("gain", 16'h6666, gain);
        lvl <= 8'hE4;
        done <= 1'b1;
        w(2);
        chk("gain", 16'h3567, gain);
        cte <= 2'h0;
        w(6);
        chk("gain", 16'h0234, gain);
        eqp <= 2'h3;
        w(6);
        chk("gain", 16'h6666, gain);
        eqp <= 2'h0;
        rwr(dss_pkg::ADDR_LEVEL_GAIN, 32'h00008765);
        rwr(dss_pkg::ADDR_CTRL, 32'h00000018);
        w(2);
        chk("gain", 16'h8765, gain);
        done <= 1'b0;
        w(2);
        chk("gain", 16'h1234, gain);
        rwr(dss_pkg::ADDR_CTRL, 32'h00000010);
        $display("t_eq done");
    endtask : t_eq
    task automatic t_switch;
        tm <= 1'b1;
        w(10);
        chk("sw", 32'h2A, sw);
        pri <= 1'b1;
        w(12);
        chk("hpd cad", 0, {hpd, cad});
        w(12);
        chk("hpd cad", 0, {hpd, cad});
        w(13);
        chk("hpd cad", 3, {hpd, cad});
        chk("sw", 32'h15, sw);
        chk("gain", 16'h1333, gain);
        sl <= 1'b1;
        w(11);
        chk("oe", 0, {oe_src[0], oe_snk[0]});
        sl <= 1'b0;
        w(11);
        chk("oe", 3, {oe_src[0], oe_snk[0]});
        $display("t_switch done");
    endtask : t_switch
    task automatic t_remove;
        dp <= 1'b0;
        tm <= 1'b0;
        w(40);
        chk("hpd", 0, hpd);
        chk("sw", 0, sw);
        chk("cad", 1, cad);
        rwr(dss_pkg::ADDR_CTRL, 32'h00000013);
        w(2);
        chk("forced", 2, {hpd, cad});
        rwr(dss_pkg::ADDR_CTRL, 32'h00000010);
        $display("t_remove done");
    endtask : t_remove
    task automatic t_enable;
        dp <= 1'b1;
        w(10);
        en <= 1'b0;
        w(10);
        chk("hpd", 1, hpd);
        chk("lanes", 0, lane_en);
        en <= 1'b1;
        w(6);
        rrd(dss_pkg::ADDR_LANE_GAIN, 32'h0);
        $display("t_enable done");
    endtask : t_enable
    task automatic finish_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    initial begin
        #40000;
        failures++;
        finish_test();
    end
    initial begin
        w(5);
        arst_n <= 1'b1;
        en <= 1'b1;
        w(6);
        t_regs();
        t_packet();
        t_eq();
        t_switch();
        t_remove();
        t_enable();
        finish_test();
    end
endmodule : dss_select_tb

// File: dss_sink_model.sv
// Sink pair and source bus driver model
`timescale 1ns/10ps
module dss_sink_model (
    input logic i_dp_on,
    input logic i_tmds_on,
    input logic i_adapter,
    input logic i_bus_low,
    output logic o_dp_hpd,
    output logic o_tmds_hpd,
    output logic o_cad,
    output logic o_below_vil
);
    assign o_dp_hpd = i_dp_on;
    assign o_tmds_hpd = i_tmds_on;
    assign o_cad = i_dp_on & i_adapter;
    assign o_below_vil = i_bus_low;
endmodule : dss_sink_model
